// ---- design/tinst_pkg.sv ----
// Package with constants and carrier types for the trap-instruction value logic
package tinst_pkg;

    // Instruction field positions
    localparam int OPC_LSB = 0;
    localparam int RD_LSB = 7;
    localparam int F3_LSB = 12;
    localparam int RS1_LSB = 15;
    localparam int RS2_LSB = 20;

    // Major opcodes of transformable instructions
    localparam logic [6:0] OPC_LOAD = 7'h03;
    localparam logic [6:0] OPC_LOADFP = 7'h07;
    localparam logic [6:0] OPC_STORE = 7'h23;
    localparam logic [6:0] OPC_STOREFP = 7'h27;
    localparam logic [6:0] OPC_AMO = 7'h2f;
    localparam logic [6:0] OPC_SYSTEM = 7'h73;
    localparam logic [2:0] F3_HYPMEM = 3'h4;
    localparam logic [6:0] F7_HYPMEM_MIN = 7'h30;

    // Pseudoinstruction codes for implicit translation accesses
    localparam logic [31:0] PSEUDO_RD32 = 32'h00002000;
    localparam logic [31:0] PSEUDO_WR32 = 32'h00002020;
    localparam logic [31:0] PSEUDO_RD64 = 32'h00003000;
    localparam logic [31:0] PSEUDO_WR64 = 32'h00003020;

    // Exception cause codes
    localparam logic [5:0] EXC_IMISALIGN = 6'h00;
    localparam logic [5:0] EXC_IACCESS = 6'h01;
    localparam logic [5:0] EXC_ILLEGAL = 6'h02;
    localparam logic [5:0] EXC_BREAK = 6'h03;
    localparam logic [5:0] EXC_LMISALIGN = 6'h04;
    localparam logic [5:0] EXC_LACCESS = 6'h05;
    localparam logic [5:0] EXC_SMISALIGN = 6'h06;
    localparam logic [5:0] EXC_SACCESS = 6'h07;
    localparam logic [5:0] EXC_IPAGE = 6'h0c;
    localparam logic [5:0] EXC_LPAGE = 6'h0d;
    localparam logic [5:0] EXC_SPAGE = 6'h0f;
    localparam logic [5:0] EXC_IGUEST = 6'h14;
    localparam logic [5:0] EXC_LGUEST = 6'h15;
    localparam logic [5:0] EXC_VIRT = 6'h16;
    localparam logic [5:0] EXC_SGUEST = 6'h17;

    // Reset value of both trap-instruction registers
    localparam logic [63:0] TINST_RESET = 64'h0;

    // Target level of a trap
    typedef enum logic [1:0] {
        LVL_MACHINE,
        LVL_HYPER,
        LVL_GUEST
    } trap_level_e;

    // One trap-entry request from the pipeline
    typedef struct packed {
        logic valid;
        trap_level_e level;
        logic interrupt;
        logic [5:0] cause;
        logic [31:0] instr;
        logic compressed;
        logic nonStandard;
        logic [31:0] customValue;
        logic implicitAccess;
        logic implicitWrite;
        logic gpaNonzero;
        logic [4:0] addrOffset;
        logic guestWidth64;
    } trap_req_s;

endpackage

// ---- design/tinst_transform.sv ----
// Combinational transform of a trapping memory instruction
`timescale 1ns/1ps

module tinst_transform (
    input wire logic [31:0] instr,
    input wire logic compressed,
    input wire logic [4:0] addrOffset,
    output logic [31:0] value,
    output logic known
);

    logic [6:0] opc;
    logic [2:0] f3;

    assign opc = instr[6:0];
    assign f3 = instr[14:12];

    always_comb begin
        value = '0;
        known = 1'b0;
        unique case (opc)
            tinst_pkg::OPC_LOAD, tinst_pkg::OPC_LOADFP: begin
                // Keep opcode, rd, function_three_field; immediate zeroed
                value = {12'h000, addrOffset, f3, instr[11:7], opc}; // see RULE_11
                known = 1'b1;
            end
            tinst_pkg::OPC_STORE, tinst_pkg::OPC_STOREFP: begin
                value = {7'h00, instr[24:20], addrOffset, f3, 5'h00, opc}; // see RULE_12
                known = 1'b1;
            end
            tinst_pkg::OPC_AMO: begin
                value = {instr[31:20], addrOffset, instr[14:0]}; // see RULE_13
                known = 1'b1;
            end
            tinst_pkg::OPC_SYSTEM: begin
                // Hypervisor guest loads and stores only
                if (f3 == tinst_pkg::F3_HYPMEM &&
                    instr[31:25] >= tinst_pkg::F7_HYPMEM_MIN) begin
                    value = {instr[31:20], addrOffset, instr[14:0]}; // see RULE_13
                    known = 1'b1;
                end
            end
            default: begin
                value = '0;
                known = 1'b0;
            end
        endcase
        // Compressed source: expanded form supplied, bit 1 cleared
        if (compressed) begin
            value[1] = 1'b0; // see RULE_15
        end
    end

endmodule

// ---- design/trap_instruction_value_gen.sv ----
// Trap-instruction register value selection and storage for M and HS levels
// Functional notes
// RULE_01 - Trap entry writes machine or hypervisor trap-instruction register automatically.
// RULE_02 - Interrupt traps always write zero.
// RULE_03 - Zero is always legal except when a pseudoinstruction code is required.
// RULE_04 - Transformed values have bit 0 set and decode as same instruction kind.
// RULE_05 - Custom values only for non-standard instructions, bit 0 set, custom space.
// RULE_06 - Pseudoinstruction codes have low bits 00; low bits 10 never written.
// RULE_07 - Fetch-preventing exceptions get only zero or a pseudoinstruction code.
// RULE_08 - Transforms only for explicit memory faults: misalign, access, page, guest.
// RULE_09 - No custom for fetch access, illegal, fetch page; pseudo only guest faults.
// RULE_10 - Standard instruction without defined transform writes zero unless pseudo needed.
// RULE_11 - Basic load keeps opcode, rd, function_three_field; upper zero; offset in 19:15.
// RULE_12 - Basic store keeps opcode, function_three_field, rs2; zero 31:25, 11:7; offset 19:15.
// RULE_13 - Atomic and guest memory instructions copy all except offset in 19:15.
// RULE_14 - Offset is positive difference of faulting and original virtual address.
// RULE_15 - Compressed: expand, transform, clear bit 1.
// RULE_16 - Implicit translation guest fault with nonzero guest address writes pseudo code.
// RULE_17 - Pseudo codes 2000/2020 for 32-bit guests, 3000/3020 for 64-bit.
// RULE_18 - Write code only for hardware A/D updates; otherwise read code.
// RULE_19 - Register not hardwired zero when pseudo codes may arise.
// RULE_20 - Software checks upper 32 bits zero before decoding a 64-bit value.
// RULE_21 - Guest-level traps write neither register.
`timescale 1ns/1ps

module trap_instruction_value_gen #(
    parameter int XLEN = 64,
    parameter bit TRANSFORM_EN = 1'b1,
    parameter bit CUSTOM_EN = 1'b1,
    parameter bit HW_AD_UPDATE = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire tinst_pkg::trap_req_s req,
    input wire logic [XLEN-1:0] faultAddr,
    input wire logic [XLEN-1:0] origAddr,
    output logic [XLEN-1:0] machineTinst,
    output logic [XLEN-1:0] hyperTinst,
    output logic machineWritten,
    output logic hyperWritten,
    output logic pseudoWritten
);

    // Only the two standard register widths can hold the codes
    if (XLEN != 32 && XLEN != 64) begin : g_bad_xlen
        $error("XLEN must be 32 or 64");
    end

    logic [31:0] xformValue;
    logic xformKnown;
    logic [4:0] offset;
    logic [XLEN-1:0] addrDiff;
    logic causeExplicitMem;
    logic causeFetch;
    logic causeGuest;
    logic causeNoCustom;
    logic needPseudo;
    logic customLegal;
    logic [31:0] pseudoCode;
    logic [31:0] chosen;
    logic [XLEN-1:0] next_machineTinst;
    logic [XLEN-1:0] next_hyperTinst;
    logic next_machineWritten;
    logic next_hyperWritten;
    logic next_pseudoWritten;

    function automatic logic is_mem_cause(input logic [5:0] c);
        return c == tinst_pkg::EXC_LMISALIGN || c == tinst_pkg::EXC_LACCESS ||
            c == tinst_pkg::EXC_SMISALIGN || c == tinst_pkg::EXC_SACCESS ||
            c == tinst_pkg::EXC_LPAGE || c == tinst_pkg::EXC_SPAGE ||
            c == tinst_pkg::EXC_LGUEST || c == tinst_pkg::EXC_SGUEST;
    endfunction

    function automatic logic is_fetch_cause(input logic [5:0] c);
        return c == tinst_pkg::EXC_IMISALIGN || c == tinst_pkg::EXC_IACCESS ||
            c == tinst_pkg::EXC_IPAGE || c == tinst_pkg::EXC_IGUEST;
    endfunction

    function automatic logic is_guest_cause(input logic [5:0] c);
        return c == tinst_pkg::EXC_IGUEST || c == tinst_pkg::EXC_LGUEST ||
            c == tinst_pkg::EXC_SGUEST;
    endfunction

    // Only misaligned accesses give a nonzero difference; low bits suffice
    assign addrDiff = faultAddr - origAddr; // see RULE_14
    assign offset = addrDiff[4:0];

    tinst_transform u_transform (
        .instr(req.instr),
        .compressed(req.compressed),
        .addrOffset(offset),
        .value(xformValue),
        .known(xformKnown)
    );

    always_comb begin
        causeExplicitMem = is_mem_cause(req.cause);
        causeFetch = is_fetch_cause(req.cause);
        causeGuest = is_guest_cause(req.cause);
        causeNoCustom = req.cause == tinst_pkg::EXC_IACCESS ||
            req.cause == tinst_pkg::EXC_ILLEGAL ||
            req.cause == tinst_pkg::EXC_IPAGE; // see RULE_09
        // Pseudo codes only for guest-page faults from implicit accesses
        needPseudo = !req.interrupt && causeGuest && req.implicitAccess &&
            req.gpaNonzero; // see RULE_16
        // Custom value must have bit 0 set; bit 1 is kept as given
        customLegal = CUSTOM_EN && req.nonStandard && !causeNoCustom &&
            !causeFetch && req.customValue[0]; // see RULE_05
        if (req.guestWidth64) begin
            pseudoCode = (HW_AD_UPDATE && req.implicitWrite) ?
                tinst_pkg::PSEUDO_WR64 : tinst_pkg::PSEUDO_RD64; // see RULE_17
        end else begin
            pseudoCode = (HW_AD_UPDATE && req.implicitWrite) ?
                tinst_pkg::PSEUDO_WR32 : tinst_pkg::PSEUDO_RD32; // see RULE_18
        end
    end

    always_comb begin
        chosen = '0; // see RULE_03
        if (req.interrupt) begin
            chosen = '0; // see RULE_02
        end else if (needPseudo) begin
            chosen = pseudoCode; // see RULE_06
        end else if (causeFetch) begin
            chosen = '0; // see RULE_07
        end else if (req.nonStandard) begin
            chosen = customLegal ? req.customValue : 32'h0;
        end else if (TRANSFORM_EN && causeExplicitMem && !req.implicitAccess &&
            xformKnown) begin
            // Bit 0 always set by transform; bit 1 marks size
            chosen = xformValue; // see RULE_08
        end else begin
            chosen = '0; // see RULE_10
        end
        if (!needPseudo && chosen[1:0] != 2'b11 && chosen[1:0] != 2'b01) begin
            chosen = '0; // see RULE_04
        end
    end

    always_comb begin
        next_machineTinst = machineTinst;
        next_hyperTinst = hyperTinst;
        next_machineWritten = 1'b0;
        next_hyperWritten = 1'b0;
        next_pseudoWritten = 1'b0;
        // Upper half stays zero so software's check always passes
        if (req.valid) begin
            unique case (req.level)
                tinst_pkg::LVL_MACHINE: begin
                    next_machineTinst = XLEN'(chosen); // see RULE_01
                    next_machineWritten = 1'b1;
                    next_pseudoWritten = needPseudo;
                end
                tinst_pkg::LVL_HYPER: begin
                    next_hyperTinst = XLEN'(chosen); // see RULE_01
                    next_hyperWritten = 1'b1;
                    next_pseudoWritten = needPseudo;
                end
                tinst_pkg::LVL_GUEST: begin
                    next_machineTinst = machineTinst; // see RULE_21
                end
                default: begin
                    next_machineTinst = machineTinst;
                end
            endcase
        end
    end

    // Full-width storage keeps pseudo codes reachable, never hardwired zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            machineTinst <= XLEN'(tinst_pkg::TINST_RESET); // see RULE_19
            hyperTinst <= XLEN'(tinst_pkg::TINST_RESET);
            machineWritten <= 1'b0;
            hyperWritten <= 1'b0;
            pseudoWritten <= 1'b0;
        end else begin
            machineTinst <= next_machineTinst;
            hyperTinst <= next_hyperTinst;
            machineWritten <= next_machineWritten;
            hyperWritten <= next_hyperWritten;
            pseudoWritten <= next_pseudoWritten;
        end
    end

endmodule

// ---- dv/trap_instruction_value_gen_monitor.sv ----
// Assertion checker bound to the trap-instruction value generator
`timescale 1ns/1ps

module trap_instruction_value_gen_monitor #(
    parameter int XLEN = 64
) (
    input wire logic clk,
    input wire logic resetn,
    input wire tinst_pkg::trap_req_s req,
    input wire logic [XLEN-1:0] faultAddr,
    input wire logic [XLEN-1:0] origAddr,
    input wire logic [XLEN-1:0] machineTinst,
    input wire logic [XLEN-1:0] hyperTinst,
    input wire logic machineWritten,
    input wire logic hyperWritten,
    input wire logic pseudoWritten
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic fetchNoCustom = req.cause == tinst_pkg::EXC_IACCESS ||
        req.cause == tinst_pkg::EXC_ILLEGAL || req.cause == tinst_pkg::EXC_IPAGE;
    wire logic pseudoNeed = req.valid && !req.interrupt && req.implicitAccess
        && req.gpaNonzero && req.level != tinst_pkg::LVL_GUEST
        && (req.cause == tinst_pkg::EXC_IGUEST
        || req.cause == tinst_pkg::EXC_LGUEST
        || req.cause == tinst_pkg::EXC_SGUEST);
    wire logic [31:0] pseudoExp = {18'h0, 1'b1, req.guestWidth64, 6'h0,
        req.implicitWrite, 5'h0};
    sequence machTrap;
        req.valid && req.level == tinst_pkg::LVL_MACHINE;
    endsequence
    sequence hypTrap;
        req.valid && req.level == tinst_pkg::LVL_HYPER;
    endsequence
    mach_entry_a:
        assert property (machTrap |=> machineWritten && !hyperWritten)
        else $error("machine trap without machine write pulse");
    hyp_entry_a:
        assert property (hypTrap |=> hyperWritten && !machineWritten)
        else $error("hypervisor trap without hypervisor write pulse");
    guest_none_a:
        assert property (req.valid && req.level == tinst_pkg::LVL_GUEST |=>
            !machineWritten && !hyperWritten && $stable(machineTinst)
            && $stable(hyperTinst))
        else $error("guest trap changed a trap-instruction register");
    intr_zero_a:
        assert property (machTrap ##0 req.interrupt |=> machineTinst == '0)
        else $error("interrupt wrote nonzero value");
    fetch_zero_a:
        assert property (machTrap ##0 (!req.interrupt && fetchNoCustom)
            |=> machineTinst == '0)
        else $error("barred cause wrote nonzero value");
    pseudo_code_a:
        assert property (pseudoNeed |=> pseudoWritten &&
            (machineWritten ? machineTinst : hyperTinst)
            == XLEN'($past(pseudoExp)))
        else $error("pseudoinstruction code missing or wrong");
    pseudo_bits_a:
        assert property (pseudoWritten |->
            (machineWritten ? machineTinst[1:0] : hyperTinst[1:0]) == 2'b00)
        else $error("pseudoinstruction code with low bits set");
    value_bits_a:
        assert property (machineWritten && !pseudoWritten
            && machineTinst != '0 |-> machineTinst[0]
            && (machineTinst >> 32) == '0)
        else $error("nonzero value with bit 0 clear or upper half set");
    upper_zero_a:
        assert property ((machineTinst >> 32) == '0
            && (hyperTinst >> 32) == '0)
        else $error("trap-instruction value has upper half set");
    mach_hold_a:
        assert property (!(req.valid && req.level == tinst_pkg::LVL_MACHINE)
            |=> $stable(machineTinst))
        else $error("machine register changed without a machine trap");
endmodule

bind trap_instruction_value_gen trap_instruction_value_gen_monitor #(
    .XLEN(XLEN)) i_monitor (.clk(clk), .resetn(resetn), .req(req),
    .faultAddr(faultAddr), .origAddr(origAddr), .machineTinst(machineTinst),
    .hyperTinst(hyperTinst), .machineWritten(machineWritten),
    .hyperWritten(hyperWritten), .pseudoWritten(pseudoWritten));

// ---- dv/testbench.sv ----
// Self-checking testbench for the trap-instruction value generator
`timescale 1ns/1ps

module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    tinst_pkg::trap_req_s req = '0;
    tinst_pkg::trap_req_s r;
    logic [63:0] faultAddr = 64'h1000;
    logic [63:0] origAddr = 64'h1000;
    logic [63:0] machineTinst, hyperTinst;
    logic machineWritten, hyperWritten, pseudoWritten;
    logic [5:0] barred [3] = '{tinst_pkg::EXC_IACCESS, tinst_pkg::EXC_ILLEGAL,
        tinst_pkg::EXC_IPAGE};
    int n_errors = 0;
    int n_tests = 0;

    always #2.5 clk = ~clk;

    trap_instruction_value_gen i_dut (.clk(clk), .resetn(resetn), .req(req),
        .faultAddr(faultAddr), .origAddr(origAddr),
        .machineTinst(machineTinst), .hyperTinst(hyperTinst),
        .machineWritten(machineWritten), .hyperWritten(hyperWritten),
        .pseudoWritten(pseudoWritten));

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic tinst_pkg::trap_req_s mk(tinst_pkg::trap_level_e lv,
        logic [5:0] c, logic [31:0] ins);
        mk = '0;
        mk.valid = 1'b1;
        mk.level = lv;
        mk.cause = c;
        mk.instr = ins;
    endfunction

    // One trap at a falling edge; pulses and target register checked a cycle on
    task automatic run(input tinst_pkg::trap_req_s t, input logic [4:0] off,
        input logic p, input logic [63:0] exp);
        req = t;
        faultAddr = origAddr + {59'h0, off};
        @(negedge clk);
        req = '0;
        chk({61'h0, machineWritten, hyperWritten, pseudoWritten},
            {61'h0, t.level == tinst_pkg::LVL_MACHINE,
            t.level == tinst_pkg::LVL_HYPER, p});
        chk(t.level == tinst_pkg::LVL_HYPER ? hyperTinst : machineTinst, exp);
    endtask

    initial begin
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        r = mk(tinst_pkg::LVL_MACHINE, tinst_pkg::EXC_LMISALIGN, 32'h00c52283);
        run(r, 5'h3, 1'b0, 64'h1a283);
        r.interrupt = 1'b1;
        run(r, 5'h3, 1'b0, 64'h0);
        r = mk(tinst_pkg::LVL_HYPER, tinst_pkg::EXC_SACCESS, 32'h00652423);
        run(r, 5'h0, 1'b0, 64'h602023);
        r = mk(tinst_pkg::LVL_MACHINE, tinst_pkg::EXC_SPAGE, 32'h046522af);
        run(r, 5'h2, 1'b0, 64'h46122af);
        r = mk(tinst_pkg::LVL_HYPER, tinst_pkg::EXC_LGUEST, 32'h680542f3);
        run(r, 5'h0, 1'b0, 64'h680042f3);
        r = mk(tinst_pkg::LVL_MACHINE, tinst_pkg::EXC_LPAGE, 32'h00052483);
        r.compressed = 1'b1;
        run(r, 5'h0, 1'b0, 64'h2481);
        r.level = tinst_pkg::LVL_GUEST;
        run(r, 5'h0, 1'b0, 64'h2481);
        r = mk(tinst_pkg::LVL_MACHINE, tinst_pkg::EXC_BREAK, 32'h00c52283);
        run(r, 5'h0, 1'b0, 64'h0);
        $display("Test transforms done");
        // Reload a custom value before each barred cause so a zero is visible
        foreach (barred[i]) begin
            r = mk(tinst_pkg::LVL_MACHINE, tinst_pkg::EXC_LACCESS, 32'h0000000b);
            r.nonStandard = 1'b1;
            r.customValue = 32'h0000000b;
            run(r, 5'h0, 1'b0, 64'hb);
            r.cause = barred[i];
            run(r, 5'h0, 1'b0, 64'h0);
        end
        r.cause = tinst_pkg::EXC_LACCESS;
        run(r, 5'h0, 1'b0, 64'hb);
        r.customValue = 32'h0000000a;
        run(r, 5'h0, 1'b0, 64'h0);
        $display("Test custom values done");
        for (int k = 0; k < 4; k++) begin
            r = mk(k[0] ? tinst_pkg::LVL_MACHINE : tinst_pkg::LVL_HYPER,
                tinst_pkg::EXC_SGUEST, 32'h00652423);
            r.implicitAccess = 1'b1;
            r.gpaNonzero = 1'b1;
            r.guestWidth64 = k[1];
            r.implicitWrite = k[0];
            run(r, 5'h0, 1'b1, {50'h0, 1'b1, k[1], 6'h0, k[0], 5'h0});
        end
        $display("Test pseudoinstructions done");
        wrap_up();
    end

    initial begin
        #5000;
        n_errors++;
        wrap_up();
    end
endmodule
